/* verif/axis_model.sv */
/*
 Behavioural model of the axis: servo drive, motor, near-point dog sensor,
 zero point signal and stroke limits.
 Assumes one travelPulse per UNIT of accumulated commanded speed.
*/
`timescale 1ns/1ps
module axis_model #(
    parameter int UNIT = 32'h0000_0010,
    parameter int DOG_ON = 32'h0000_0032,
    parameter int DOG_OFF = 32'h0000_0078,
    parameter int ZERO_PER = 32'h0000_0040,
    parameter int ZERO_OFF = 32'h0000_001E,
    parameter int ZERO_W = 32'h0000_0003,
    parameter int UPPER_POS = 32'h0000_0258,
    parameter int LOWER_POS = -32'sh0000_0258
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Drive command
    input wire logic [homing_pkg::SPD_W-1:0] motionSpeed,
    input wire logic motionDir,
    // Bench control
    input wire logic homeClr,
    input wire logic signed [31:0] loadPos,
    input wire logic zeroEnable,
    // Axis pins
    output logic proximityDog,
    output logic zeroPulse,
    output logic upperLimit,
    output logic lowerLimit,
    output logic travelPulse,
    // Position seen by the bench
    output logic signed [31:0] axisPos
);
    logic [31:0] acc;
    // ------------------------------------------------------------
    // Motor integration
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc <= 32'h0000_0000;
            axisPos <= 32'sh0000_0000;
            travelPulse <= 1'b0;
        end else if (homeClr) begin
            acc <= 32'h0000_0000;
            axisPos <= loadPos;
            travelPulse <= 1'b0;
        end else if (acc + 32'(motionSpeed) >= UNIT) begin
            acc <= acc + 32'(motionSpeed) - UNIT;
            axisPos <= motionDir ? axisPos + 1 : axisPos - 1;
            travelPulse <= 1'b1;
        end else begin
            acc <= acc + 32'(motionSpeed);
            travelPulse <= 1'b0;
        end
    end
    // dog off far from zero
    // Dog OFF sits between the zero marks at 94 and 158
    assign proximityDog = (axisPos >= DOG_ON) && (axisPos <= DOG_OFF);
    // Mark spans a few units so the pin filter still sees it at homing speed
    assign zeroPulse = zeroEnable && (axisPos >= 0) && ((axisPos % ZERO_PER) >= ZERO_OFF)
        && ((axisPos % ZERO_PER) < ZERO_OFF + ZERO_W);
    assign upperLimit = axisPos >= UPPER_POS;
    assign lowerLimit = axisPos <= LOWER_POS;
endmodule : axis_model

/* verif/tb_count_homing_sequencer.sv */
/*
 Self-checking bench for the count-method homing sequencer.
 Assumes axis_model on the far side; inputs change on the falling edge.
*/
`timescale 1ns/1ps
module tb_count_homing_sequencer;
    localparam logic [15:0] HS = 16'h0010;
    localparam logic [15:0] CS = 16'h0004;
    localparam logic [31:0] DIST = 32'h0000_00C8;
    logic core_clk, rst, homing_method, homing_direction, homingStart, stopCmd, restartCmd;
    logic homeClr, zeroEnable, proximityDog, zeroPulse, upperLimit, lowerLimit, travelPulse;
    logic motionDir, busy;
    logic [15:0] homing_speed, creep_speed, homing_accel_time_select, motionSpeed, axis_status_word, peakSpd;
    logic [31:0] post_dog_travel_distance;
    logic signed [31:0] loadPos, axisPos;
    logic [homing_pkg::ERR_W-1:0] errorCode;
    int mismatches = 0;
    int n_checks = 0;

    count_homing_sequencer uut (.core_clk(core_clk), .rst(rst), .homing_method(homing_method),
        .homing_direction(homing_direction), .homing_speed(homing_speed), .creep_speed(creep_speed),
        .post_dog_travel_distance(post_dog_travel_distance), .homing_accel_time_select(homing_accel_time_select),
        .homingStart(homingStart), .stopCmd(stopCmd), .restartCmd(restartCmd), .proximityDog(proximityDog),
        .zeroPulse(zeroPulse), .upperLimit(upperLimit), .lowerLimit(lowerLimit), .travelPulse(travelPulse),
        .motionSpeed(motionSpeed), .motionDir(motionDir), .axis_status_word(axis_status_word),
        .errorCode(errorCode), .busy(busy));
    axis_model axis (.core_clk(core_clk), .rst(rst), .motionSpeed(motionSpeed), .motionDir(motionDir),
        .homeClr(homeClr), .loadPos(loadPos), .zeroEnable(zeroEnable), .proximityDog(proximityDog),
        .zeroPulse(zeroPulse), .upperLimit(upperLimit), .lowerLimit(lowerLimit), .travelPulse(travelPulse),
        .axisPos(axisPos));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Peak speed of the current run, cleared with the axis
    always @(posedge core_clk) begin
        if (homeClr) begin
            peakSpd <= 16'h0000;
        end else if (motionSpeed > peakSpd) begin
            peakSpd <= motionSpeed;
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task automatic start_homing(input logic m, input logic [31:0] d);
        @(negedge core_clk);
        homing_method = m;
        post_dog_travel_distance = d;
        homingStart = 1'b1;
        @(negedge core_clk);
        homingStart = 1'b0;
    endtask : start_homing
    task automatic pulse(ref logic s);
        @(negedge core_clk);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask : pulse
    task automatic clr_axis(input logic signed [31:0] p, input logic zen);
        loadPos = p;
        zeroEnable = zen;
        pulse(homeClr);
        repeat (6) @(negedge core_clk);
    endtask : clr_axis
    // Speed waits are bounded; a miss shows in the compare that follows
    task automatic wait_speed(input logic [15:0] v, input int lim);
        for (int i = 0; i < lim && motionSpeed !== v; i++) @(negedge core_clk);
    endtask : wait_speed
    task automatic wait_idle();
        repeat (3) @(negedge core_clk);
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge core_clk);
        check(32'(busy), 32'h0000_0000);
    endtask : wait_idle
    function automatic logic [31:0] flags();
        return 32'({axis_status_word[4], axis_status_word[3]});
    endfunction : flags
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {rst, homing_direction} = 2'h3;
        {homing_method, homingStart, stopCmd, restartCmd, homeClr} = 5'h00;
        zeroEnable = 1'b1;
        loadPos = 32'sh0000_0000;
        homing_speed = HS;
        creep_speed = CS;
        homing_accel_time_select = 16'h0001;
        post_dog_travel_distance = DIST;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        repeat (5) @(negedge core_clk);
        check(32'(axis_status_word), 32'h0000_0008);
        check(32'(errorCode), 32'h0000_0000);
        // one short of the deceleration distance
        start_homing(1'b0, 32'h0000_0077);
        repeat (4) @(negedge core_clk);
        check(32'(errorCode), 32'h0000_00CE);
        check(32'(busy), 32'h0000_0000);
        check(32'(motionSpeed), 32'h0000_0000);
        // Method 1, zero mark passed before the dog
        start_homing(1'b0, DIST);
        repeat (3) @(negedge core_clk);
        check(flags(), 32'h0000_0001);
        check(32'(motionDir), 32'h0000_0001);
        wait_speed(HS, 200);
        check(32'(motionSpeed), 32'(HS));
        wait_speed(CS, 400);
        check(32'(motionSpeed), 32'(CS));
        wait_idle();
        check(flags(), 32'h0000_0002);
        check(32'(errorCode), 32'h0000_0000);
        check(32'((axisPos - 30) % 64 <= 2), 32'h0000_0001);
        check(32'(axisPos >= 250), 32'h0000_0001);
        start_homing(1'b0, DIST);
        repeat (3) @(negedge core_clk);
        check(32'(errorCode), 32'h0000_0000);
        wait_speed(HS, 200);
        check(32'(motionSpeed), 32'(HS));
        wait_speed(16'h0000, 2000);
        check(32'(upperLimit), 32'h0000_0001);
        clr_axis(32'sh0000_003C, 1'b1);
        start_homing(1'b0, DIST);
        wait_idle();
        check(flags(), 32'h0000_0002);
        check(32'(peakSpd <= CS), 32'h0000_0001);
        check(32'(axisPos >= 260), 32'h0000_0001);
        clr_axis(32'sh0000_0000, 1'b0);
        start_homing(1'b0, DIST);
        wait_idle();
        check(32'(errorCode), 32'h0000_00D2);
        check(32'(motionSpeed), 32'h0000_0000);
        // method 2 at the exact deceleration distance
        clr_axis(32'sh0000_0000, 1'b0);
        start_homing(1'b1, 32'h0000_0078);
        wait_idle();
        check(flags(), 32'h0000_0002);
        check(32'(errorCode), 32'h0000_0000);
        check(32'(axisPos >= 170 && axisPos <= 180), 32'h0000_0001);
        clr_axis(32'sh0000_0000, 1'b1);
        start_homing(1'b0, DIST);
        wait_speed(HS, 200);
        pulse(stopCmd);
        wait_speed(16'h0000, 200);
        pulse(restartCmd);
        repeat (3) @(negedge core_clk);
        check(32'(errorCode), 32'h0000_00D1);
        check(32'(motionSpeed), 32'h0000_0000);
        conclude();
    end
    // The whole test takes a few thousand cycles; this bound is generous
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        conclude();
    end
endmodule : tb_count_homing_sequencer

/* verilog/count_homing_sequencer.sv */
/*
 Count-method homing sequencer for one axis: ramps speed, counts travel after
 the near-point dog, finds the zero point pulse, reports completion and errors.
 Assumes the motor drive integrates motionSpeed into position feedback pulses
 (one travelPulse per unit moved) and that dog and zero inputs are raw pins.
*/
// Behaviour
// - Start ramps up in the set direction to homing speed
// - Dog ON starts deceleration to creep speed, then creep
// - Method 1: after travel distance stop, creep again, stop at zero pulse
// - Completion sets done bit 4, clears request bit 3
// - Travel shorter than decel distance gives error 206, start refused
// - Method 1: no zero pulse by end of travel gives 210, stop
// - Restart after a stop-signal halt gives error 209
// - Start accepted with dog already ON
// - New start allowed right after completion, no error
// - Method 2: stop at end of travel, complete without zero search
// - Method 2 final position spreads with dog sampling of about 1 ms; here the dog is sampled every core_clk cycle, DOG_SAMPLE_CYC is unused
// - Dog turning OFF mid-homing does not disturb the sequence
// - Restart with dog OFF runs at homing speed until a stroke limit
`timescale 1ns/1ps
module count_homing_sequencer #(
    parameter int SPD_W = homing_pkg::SPD_W,
    parameter int POS_W = homing_pkg::POS_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Configuration
    input wire logic homing_method,
    input wire logic homing_direction,
    input wire logic [SPD_W-1:0] homing_speed,
    input wire logic [SPD_W-1:0] creep_speed,
    input wire logic [POS_W-1:0] post_dog_travel_distance,
    input wire logic [SPD_W-1:0] homing_accel_time_select,
    // Commands
    input wire logic homingStart,
    input wire logic stopCmd,
    input wire logic restartCmd,
    // Axis pins
    input wire logic proximityDog,
    input wire logic zeroPulse,
    input wire logic upperLimit,
    input wire logic lowerLimit,
    input wire logic travelPulse,
    // Drive outputs
    output logic [SPD_W-1:0] motionSpeed,
    output logic motionDir,
    // Status
    output logic [15:0] axis_status_word,
    output logic [homing_pkg::ERR_W-1:0] errorCode,
    output logic busy
);
    typedef enum {IDLE, ACCEL, DECEL, CREEP, STOP1, SEEK, HALTING, HALTED} state_t;
    state_t state_r;
    logic [2:0] dogSync_r, zeroSync_r, upSync_r, loSync_r;
    logic dogLvl_r, zeroLvl_r, upLvl_r, loLvl_r, dogPrev_r, zeroPrev_r, dogRise, zeroRise;
    logic [SPD_W-1:0] targetSpeed_r, rampSpeed;
    logic [POS_W-1:0] travelCnt_r, decelDist;
    logic counting_r, zeroSeen_r, travelDone, rampAt;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Level moves only once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dogSync_r <= '0;
            zeroSync_r <= '0;
            upSync_r <= '0;
            loSync_r <= '0;
            dogLvl_r <= 1'b0;
            zeroLvl_r <= 1'b0;
            upLvl_r <= 1'b0;
            loLvl_r <= 1'b0;
            dogPrev_r <= 1'b0;
            zeroPrev_r <= 1'b0;
        end else begin
            dogSync_r <= {dogSync_r[1:0], proximityDog};
            zeroSync_r <= {zeroSync_r[1:0], zeroPulse};
            upSync_r <= {upSync_r[1:0], upperLimit};
            loSync_r <= {loSync_r[1:0], lowerLimit};
            if (dogSync_r[1] == dogSync_r[2]) dogLvl_r <= dogSync_r[2];
            if (zeroSync_r[1] == zeroSync_r[2]) zeroLvl_r <= zeroSync_r[2];
            if (upSync_r[1] == upSync_r[2]) upLvl_r <= upSync_r[2];
            if (loSync_r[1] == loSync_r[2]) loLvl_r <= loSync_r[2];
            dogPrev_r <= dogLvl_r;
            zeroPrev_r <= zeroLvl_r;
        end
    end
    // dog edge latency
    // Sampling delay makes method 2 stop spread with dog timing
    assign dogRise = dogLvl_r & ~dogPrev_r;
    assign zeroRise = zeroLvl_r & ~zeroPrev_r;
    // ------------------------------------------------------------
    // Deceleration distance estimate
    // ------------------------------------------------------------
    // Travel units per ramp: (v1^2 - v0^2) / (2*step), rounded up
    function automatic logic [POS_W-1:0] rampDist(input logic [SPD_W-1:0] hi, lo, st);
        logic [2*SPD_W:0] num;
        logic [2*SPD_W:0] den;
        num = (2*SPD_W+1)'(hi) * (2*SPD_W+1)'(hi) - (2*SPD_W+1)'(lo) * (2*SPD_W+1)'(lo);
        den = {1'b0, {SPD_W{1'b0}}, st} << 1;
        if (den == '0) den = (2*SPD_W+1)'(1);
        rampDist = POS_W'((num + den - 1'b1) / den);
    endfunction : rampDist
    assign decelDist = (homing_speed > creep_speed) ?
        rampDist(homing_speed, creep_speed, homing_accel_time_select) : '0;
    speed_ramp #(.SPD_W(SPD_W)) ramp_u (
        .core_clk(core_clk),
        .rst(rst),
        .targetSpeed(targetSpeed_r),
        .stepSize(homing_accel_time_select),
        .curSpeed(rampSpeed),
        .atTarget(rampAt)
    );
    assign travelDone = counting_r && (travelCnt_r >= post_dog_travel_distance);
    // ------------------------------------------------------------
    // Post-dog travel counter and zero memory
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            travelCnt_r <= '0;
            counting_r <= 1'b0;
        end else if (state_r == IDLE || state_r == HALTED) begin
            travelCnt_r <= '0;
            counting_r <= homingStart && dogLvl_r;
        end else if (state_r == ACCEL && dogRise) begin
            travelCnt_r <= '0;
            counting_r <= 1'b1;
        end else if (counting_r && travelPulse && !travelDone) begin
            travelCnt_r <= POS_W'(travelCnt_r + 1'b1);
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) zeroSeen_r <= 1'b0;
        else if (state_r == IDLE || state_r == HALTED) zeroSeen_r <= 1'b0;
        else if (zeroRise) zeroSeen_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= IDLE;
            targetSpeed_r <= '0;
            motionDir <= 1'b0;
            errorCode <= homing_pkg::ERR_NONE;
            axis_status_word <= homing_pkg::STAT_RESET;
        end else begin
            unique case (state_r)
                IDLE, HALTED: begin
                    targetSpeed_r <= '0;
                    if (state_r == HALTED && restartCmd) begin
                        errorCode <= homing_pkg::ERR_RESTART;
                        state_r <= IDLE;
                    end else if (homingStart) begin
                        if (post_dog_travel_distance < decelDist) begin
                            errorCode <= homing_pkg::ERR_COUNT_DIST;
                            state_r <= IDLE;
                        end else begin
                            errorCode <= homing_pkg::ERR_NONE;
                            axis_status_word[homing_pkg::STAT_DONE_BIT] <= 1'b0;
                            axis_status_word[homing_pkg::STAT_REQ_BIT] <= 1'b1;
                            motionDir <= homing_direction;
                            if (dogLvl_r) begin
                                targetSpeed_r <= creep_speed;
                                state_r <= CREEP;
                            end else begin
                                targetSpeed_r <= homing_speed;
                                state_r <= ACCEL;
                            end
                        end
                    end
                end
                ACCEL: begin
                    if (stopCmd) begin
                        targetSpeed_r <= '0;
                        state_r <= HALTING;
                    end else if (dogRise) begin
                        targetSpeed_r <= creep_speed;
                        state_r <= DECEL;
                    end else if ((homing_direction ? upLvl_r : loLvl_r)) begin
                        targetSpeed_r <= '0;
                        state_r <= HALTING;
                    end
                end
                DECEL, CREEP: begin
                    if (stopCmd) begin
                        targetSpeed_r <= '0;
                        state_r <= HALTING;
                    end else if (travelDone) begin
                        targetSpeed_r <= '0;
                        if (homing_method == homing_pkg::METHOD_COUNT2) begin
                            state_r <= STOP1;
                        end else if (!zeroSeen_r && !zeroRise) begin
                            errorCode <= homing_pkg::ERR_NO_ZERO;
                            state_r <= HALTING;
                        end else begin
                            state_r <= STOP1;
                        end
                    end else if (rampAt) begin
                        state_r <= CREEP;
                    end
                end
                STOP1: begin
                    if (stopCmd) begin
                        targetSpeed_r <= '0;
                        state_r <= HALTING;
                    end else if (rampSpeed == '0) begin
                        if (homing_method == homing_pkg::METHOD_COUNT2) begin
                            axis_status_word[homing_pkg::STAT_DONE_BIT] <= 1'b1;
                            axis_status_word[homing_pkg::STAT_REQ_BIT] <= 1'b0;
                            state_r <= IDLE;
                        end else begin
                            targetSpeed_r <= creep_speed;
                            state_r <= SEEK;
                        end
                    end
                end
                SEEK: begin
                    if (stopCmd) begin
                        targetSpeed_r <= '0;
                        state_r <= HALTING;
                    end else if (zeroRise) begin
                        targetSpeed_r <= '0;
                        axis_status_word[homing_pkg::STAT_DONE_BIT] <= 1'b1;
                        axis_status_word[homing_pkg::STAT_REQ_BIT] <= 1'b0;
                        state_r <= IDLE;
                    end
                end
                HALTING: begin
                    targetSpeed_r <= '0;
                    if (rampSpeed == '0) state_r <= HALTED;
                end
            endcase
        end
    end

    // Drive speed straight from the ramp register; zero-pulse stop is abrupt
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            motionSpeed <= '0;
            busy <= 1'b0;
        end else begin
            motionSpeed <= (state_r == IDLE || state_r == HALTED) ? '0 : rampSpeed;
            busy <= !(state_r == IDLE || state_r == HALTED);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    short_dist_a: assert property ((state_r == IDLE) && homingStart && (post_dog_travel_distance < decelDist)
        |=> (errorCode == homing_pkg::ERR_COUNT_DIST) && (state_r == IDLE))
        else $error("short travel start not refused");
    done_flags_a: assert property ((state_r == SEEK) && !stopCmd && zeroRise
        |=> axis_status_word[4] && !axis_status_word[3])
        else $error("completion flags wrong");
    dog_decel_a: assert property ((state_r == ACCEL) && !stopCmd && dogRise
        |=> (targetSpeed_r == creep_speed))
        else $error("dog did not slow to creep");
    no_zero_a: assert property ((state_r == CREEP) && !stopCmd && travelDone && !homing_method
        && !zeroSeen_r && !zeroRise |=> (errorCode == homing_pkg::ERR_NO_ZERO) ##1 (targetSpeed_r == '0))
        else $error("missing zero not reported");
    restart_err_a: assert property ((state_r == HALTED) && restartCmd
        |=> (errorCode == homing_pkg::ERR_RESTART))
        else $error("restart after stop not refused");
    dog_start_a: assert property ((state_r == IDLE) && homingStart && dogLvl_r
        && (post_dog_travel_distance >= decelDist) |=> (state_r == CREEP) && counting_r)
        else $error("start on dog not accepted");
    m2_done_a: assert property ((state_r == STOP1) && homing_method && !stopCmd && (rampSpeed == '0)
        |=> axis_status_word[4] && !axis_status_word[3] && (state_r == IDLE))
        else $error("method 2 completion wrong");
    accel_start_a: assert property ((state_r == IDLE) && homingStart && !dogLvl_r
        && (post_dog_travel_distance >= decelDist) |=> (targetSpeed_r == homing_speed) && (motionDir == $past(homing_direction)))
        else $error("start did not target homing speed");
endmodule : count_homing_sequencer

/* verilog/homing_pkg.sv */
/*
 Constants for the count-method homing sequencer: error codes, status bit
 positions, speed and distance widths, sampling figures.
 Assumes a single 10 MHz core clock.
*/
package homing_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int DOG_SAMPLE_NS = 1000000;
    localparam int DOG_SAMPLE_CYC = (DOG_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SPD_W = 16;
    localparam int POS_W = 32;
    localparam int ERR_W = 12;
    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int STAT_REQ_BIT = 3;
    localparam int STAT_DONE_BIT = 4;
    localparam logic [15:0] STAT_RESET = 16'h0008;
    // ------------------------------------------------------------
    // Error codes
    // ------------------------------------------------------------
    localparam logic [ERR_W-1:0] ERR_NONE = 12'h000;
    localparam logic [ERR_W-1:0] ERR_COUNT_DIST = 12'h0CE;
    localparam logic [ERR_W-1:0] ERR_RESTART = 12'h0D1;
    localparam logic [ERR_W-1:0] ERR_NO_ZERO = 12'h0D2;
    // ------------------------------------------------------------
    // Methods
    // ------------------------------------------------------------
    localparam logic METHOD_COUNT1 = 1'b0;
    localparam logic METHOD_COUNT2 = 1'b1;
endpackage : homing_pkg

/* verilog/speed_ramp.sv */
/*
 Linear speed ramp: steps the commanded speed toward a target by a fixed
 increment each clock. Assumes the step is nonzero.
*/
`timescale 1ns/1ps
module speed_ramp #(
    parameter int SPD_W = homing_pkg::SPD_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Ramp control
    input wire logic [SPD_W-1:0] targetSpeed,
    input wire logic [SPD_W-1:0] stepSize,
    // Result
    output logic [SPD_W-1:0] curSpeed,
    output logic atTarget
);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            curSpeed <= '0;
        end else if (curSpeed + stepSize <= targetSpeed && curSpeed < targetSpeed) begin
            curSpeed <= SPD_W'(curSpeed + stepSize);
        end else if (curSpeed < targetSpeed) begin
            curSpeed <= targetSpeed;
        end else if (curSpeed >= targetSpeed + stepSize) begin
            curSpeed <= SPD_W'(curSpeed - stepSize);
        end else begin
            curSpeed <= targetSpeed;
        end
    end

    assign atTarget = (curSpeed == targetSpeed);
endmodule : speed_ramp
